/* include/ucs_params.svh */
`ifndef UCS_PARAMS_SVH
`define UCS_PARAMS_SVH

`define UCS_CLK_PERIOD_NS  10

`define UCS_A_KEY          8'h00
`define UCS_A_CTL          8'h04
`define UCS_A_USS          8'h08
`define UCS_A_STS          8'h0C
`define UCS_A_MASK         8'h10
`define UCS_A_STAT         8'h14

`define UCS_KEY            8'hA5
`define UCS_KEY_LSB        8

`define UCS_CTL_RANGE_LSB  0
`define UCS_CTL_BYPASS     2
`define UCS_CTL_HFEN       3
`define UCS_CTL_SMSRC      4
`define UCS_CTL_DIV_LSB    8

`define UCS_USS_RESTYPE    0
`define UCS_USS_EN         1
`define UCS_USS_PWR        2

`define UCS_ST_STARTED     0
`define UCS_ST_READY       1
`define UCS_ST_LOCK        2
`define UCS_ST_FALLBACK    3
`define UCS_ST_UNLOCKED    4

`define UCS_S_HF           0
`define UCS_S_LF           1
`define UCS_S_GLOBAL       2
`define UCS_S_STARTED      3
`define UCS_S_READY        4
`define UCS_S_LOCK         5
`define UCS_S_W            6

`define UCS_START_XTAL     13'd4096
`define UCS_START_CERAMIC  13'd512

`define UCS_RANGE1_MHZ     4
`define UCS_RANGE2_MHZ     8
`define UCS_RANGE3_MHZ     16
`define UCS_RANGE4_MHZ     24
`define UCS_HF_MISS_NS     1000
`define UCS_MOD_MHZ        5
`define UCS_DIV_MAX        3'd5

`define UCS_SYNC_W         6

`endif

/* include/ucs_pkg.sv */
`include "ucs_params.svh"

package ucs_pkg;

  typedef enum logic [1:0] {
    UCS_OSC_OFF,
    UCS_OSC_WAIT,
    UCS_OSC_RUN
  } ucs_osc_t;

  typedef struct packed {
    logic uss;
    logic hf_in;
    logic hf_xtal;
    logic lf_fault;
    logic ready;
    logic lock;
  } ucs_pins_t;

  typedef struct packed {
    ucs_pins_t s1;
    ucs_pins_t s2;
  } ucs_sync_t;

  typedef struct packed {
    logic                  unlocked;
    logic [1:0]            range;
    logic                  bypass;
    logic                  hf_en;
    logic                  sm_src;
    logic [2:0]            div;
    logic                  res_type;
    logic                  uss_en;
    logic                  pwr_en;
    ucs_osc_t              osc;
    logic [12:0]           start_cnt;
    logic [`UCS_S_W-1:0]   sts;
    logic [`UCS_S_W-1:0]   mask;
    logic [7:0]            per_cnt;
    logic [3:0]            mod_cnt;
    logic                  mod_clk;
    logic [4:0]            sm_cnt;
    logic                  uss_prev;
    logic                  hf_prev;
    logic                  sel_prev;
    logic                  ready_prev;
    logic                  lock_prev;
    logic                  pend_wr;
    logic                  pend_rd;
    logic [7:0]            pend_addr;
    logic                  hreadyout;
    logic [31:0]           hrdata;
    logic                  hresp;
    logic                  buf_out;
    logic                  xtal_en;
    logic                  hf_clk;
    logic                  sm_clk;
    logic                  pwr_out;
    logic                  irq;
  } ucs_state_t;

endpackage : ucs_pkg

/* hdl/ucs_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module ucs_sync (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire ucs_pkg::ucs_pins_t din,
  output ucs_pkg::ucs_pins_t      dout
);

  ucs_pkg::ucs_sync_t q;
  ucs_pkg::ucs_sync_t d;

  // First stage feeds only the second stage
  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule : ucs_sync

`default_nettype wire

/* hdl/ucs_clock_ctl.sv */
// Functional notes
// - The two-bit range field picks up to 4, 4-8, 8-16 or 16-24 MHz and must match the applied clock.
// - In bypass mode the hf oscillator takes the external clock on its input pin instead of a crystal.
// - The subsystem clock comes from the hf oscillator clock, or the internal oscillator when sm_src is set, through a divider; divide-by-one passes it.
// - Writing 1 to the ultrasonic oscillator enable starts the ultrasonic oscillator.
// - A status bit shows that the ultrasonic oscillator has started.
// - Once started, the buffered ultrasonic clock output is driven.
// - After oscillator start software may power the supply and wait for ready and pll lock.
// - While the hf fault flag is set, hf-sourced clocks come from the internal 5 MHz oscillator.
// - The global fault flag is set whenever the hf or lf fault flag is set.
`timescale 1ns/1ps
`default_nettype none

module ucs_clock_ctl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        uss_osc_pin,
  input  wire logic        hf_clock_input_pin,
  input  wire logic        hf_xtal_pin,
  input  wire logic        lf_fault_pin,
  input  wire logic        supply_ready_pin,
  input  wire logic        pll_lock_pin,
  output logic             ultrasonic_osc_enable,
  output logic             ultrasonic_clock_buffered_out,
  output logic             hf_xtal_drive_en,
  output logic             hf_oscillator_clock,
  output logic             subsystem_clock,
  output logic             ultrasonic_power_supply_en,
  output logic             irq
);

  localparam int unsigned MOD_HALF = 1000 / (`UCS_MOD_MHZ * `UCS_CLK_PERIOD_NS) / 2;
  localparam int unsigned MISS_CYC = `UCS_HF_MISS_NS / `UCS_CLK_PERIOD_NS;

  // Shortest legal edge spacing, one cycle of slack for sampling jitter
  function automatic logic [7:0] per_lo(input int unsigned mhz);
    int unsigned c;
    c = 1000 / (mhz * `UCS_CLK_PERIOD_NS);
    per_lo = (c > 1) ? 8'(c - 1) : 8'd1;
  endfunction : per_lo

  // Longest legal edge spacing, rounded up plus one cycle of slack
  function automatic logic [7:0] per_hi(input int unsigned mhz);
    int unsigned c;
    c = (1000 + mhz * `UCS_CLK_PERIOD_NS - 1) / (mhz * `UCS_CLK_PERIOD_NS);
    per_hi = 8'(c + 1);
  endfunction : per_hi

  ucs_pkg::ucs_pins_t  pins_raw;
  ucs_pkg::ucs_pins_t  pins;
  ucs_pkg::ucs_state_t q;
  ucs_pkg::ucs_state_t d;

  logic                accept;
  logic                hf_src;
  logic                hf_rise;
  logic                hf_bad;
  logic [7:0]          per_min;
  logic [7:0]          per_max;
  logic                sel_src;
  logic                sel_rise;
  logic                uss_rise;
  logic [2:0]          dv;
  logic [12:0]         start_target;
  logic [`UCS_S_W-1:0] set_v;
  logic [`UCS_S_W-1:0] clr_v;
  logic [31:0]         rdata;

  assign pins_raw.uss      = uss_osc_pin;
  assign pins_raw.hf_in    = hf_clock_input_pin;
  assign pins_raw.hf_xtal  = hf_xtal_pin;
  assign pins_raw.lf_fault = lf_fault_pin;
  assign pins_raw.ready    = supply_ready_pin;
  assign pins_raw.lock     = pll_lock_pin;

  ucs_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (pins_raw),
    .dout    (pins)
  );

  always_comb begin
    d     = q;
    set_v = '0;
    clr_v = '0;
    rdata = '0;

    // Hf oscillator source
    hf_src  = q.bypass ? pins.hf_in : pins.hf_xtal;
    hf_rise = hf_src & ~q.hf_prev;
    d.hf_prev = hf_src;
    d.xtal_en = q.hf_en & ~q.bypass;

    // Edge spacing window per range
    case (q.range)
      2'b00: begin
        per_min = per_lo(`UCS_RANGE1_MHZ);
        per_max = 8'(MISS_CYC);
      end
      2'b01: begin
        per_min = per_lo(`UCS_RANGE2_MHZ);
        per_max = per_hi(`UCS_RANGE1_MHZ);
      end
      2'b10: begin
        per_min = per_lo(`UCS_RANGE3_MHZ);
        per_max = per_hi(`UCS_RANGE2_MHZ);
      end
      default: begin
        per_min = per_lo(`UCS_RANGE4_MHZ);
        per_max = per_hi(`UCS_RANGE3_MHZ);
      end
    endcase

    if (!q.hf_en || hf_rise) begin
      d.per_cnt = '0;
    end else if (q.per_cnt != 8'hFF) begin
      d.per_cnt = q.per_cnt + 8'h01;
    end

    // Level condition, so a clear while the clock is still bad is re-set
    hf_bad = q.hf_en & ((hf_rise & ((9'(q.per_cnt) + 9'h001) < 9'(per_min)))
                        | (q.per_cnt > per_max));

    // Internal module oscillator from the bus clock
    if (q.mod_cnt == 4'(MOD_HALF - 1)) begin
      d.mod_cnt = '0;
      d.mod_clk = ~q.mod_clk;
    end else begin
      d.mod_cnt = q.mod_cnt + 4'h1;
    end

    // Fallback while the hf fault flag stands
    d.hf_clk = q.sts[`UCS_S_HF] ? q.mod_clk : hf_src;
    sel_src  = (q.sts[`UCS_S_HF] | q.sm_src) ? q.mod_clk : hf_src;

    // Subsystem clock divider; ratio 2^div, capped
    sel_rise   = sel_src & ~q.sel_prev;
    d.sel_prev = sel_src;
    dv         = (q.div > `UCS_DIV_MAX) ? `UCS_DIV_MAX : q.div;
    if (sel_rise) begin
      d.sm_cnt = q.sm_cnt + 5'h01;
    end
    if (dv == 3'd0) begin
      d.sm_clk = sel_src;
    end else begin
      d.sm_clk = q.sm_cnt[dv - 3'd1];
    end

    // Ultrasonic oscillator start-up
    uss_rise     = pins.uss & ~q.uss_prev;
    d.uss_prev   = pins.uss;
    start_target = q.res_type ? `UCS_START_CERAMIC : `UCS_START_XTAL;
    case (q.osc)
      ucs_pkg::UCS_OSC_OFF: begin
        d.start_cnt = '0;
        if (q.uss_en) begin
          d.osc = ucs_pkg::UCS_OSC_WAIT;
        end
      end
      ucs_pkg::UCS_OSC_WAIT: begin
        if (!q.uss_en) begin
          d.osc = ucs_pkg::UCS_OSC_OFF;
        end else if (uss_rise) begin
          if (q.start_cnt + 13'd1 == start_target) begin
            d.osc = ucs_pkg::UCS_OSC_RUN;
            set_v[`UCS_S_STARTED] = 1'b1;
          end else begin
            d.start_cnt = q.start_cnt + 13'd1;
          end
        end
      end
      ucs_pkg::UCS_OSC_RUN: begin
        if (!q.uss_en) begin
          d.osc = ucs_pkg::UCS_OSC_OFF;
        end
      end
      default: begin
        d.osc = ucs_pkg::UCS_OSC_OFF;
      end
    endcase

    // Buffer only a started oscillator; unsuited as processor clock
    d.buf_out = (q.osc == ucs_pkg::UCS_OSC_RUN) & pins.uss;

    // Supply only powers once the oscillator runs
    d.pwr_out    = q.pwr_en & (q.osc == ucs_pkg::UCS_OSC_RUN);
    d.ready_prev = pins.ready;
    d.lock_prev  = pins.lock;
    set_v[`UCS_S_READY] = pins.ready & ~q.ready_prev;
    set_v[`UCS_S_LOCK]  = pins.lock & ~q.lock_prev;

    // Fault flags
    set_v[`UCS_S_HF]     = hf_bad;
    set_v[`UCS_S_LF]     = pins.lf_fault;
    set_v[`UCS_S_GLOBAL] = q.sts[`UCS_S_HF] | q.sts[`UCS_S_LF] | hf_bad | pins.lf_fault;

    // Bus address phase
    accept      = hsel & htrans[1] & hready;
    d.pend_wr   = accept & hwrite;
    d.pend_rd   = accept & ~hwrite;
    d.hresp     = 1'b0;
    if (accept) begin
      d.pend_addr = {haddr[7:2], 2'b00};
      d.hreadyout = hwrite;
    end

    // Write data phase
    if (q.pend_wr) begin
      case (q.pend_addr)
        `UCS_A_KEY: begin
          d.unlocked = (hwdata[`UCS_KEY_LSB +: 8] == `UCS_KEY);
        end
        `UCS_A_CTL: begin
          if (q.unlocked) begin
            d.range  = hwdata[`UCS_CTL_RANGE_LSB +: 2];
            d.bypass = hwdata[`UCS_CTL_BYPASS];
            d.hf_en  = hwdata[`UCS_CTL_HFEN];
            d.sm_src = hwdata[`UCS_CTL_SMSRC];
            d.div    = hwdata[`UCS_CTL_DIV_LSB +: 3];
          end
        end
        `UCS_A_USS: begin
          // Type is frozen while enabled so a running count cannot change target
          if (!q.uss_en) begin
            d.res_type = hwdata[`UCS_USS_RESTYPE];
          end
          d.uss_en = hwdata[`UCS_USS_EN];
          d.pwr_en = hwdata[`UCS_USS_PWR];
        end
        `UCS_A_STS: begin
          clr_v = hwdata[`UCS_S_W-1:0];
          if (!q.unlocked) begin
            clr_v[`UCS_S_HF] = 1'b0;
            clr_v[`UCS_S_LF] = 1'b0;
          end
        end
        `UCS_A_MASK: begin
          d.mask = hwdata[`UCS_S_W-1:0];
        end
        default: begin
          d.mask = q.mask;
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    d.sts = (q.sts & ~clr_v) | set_v;
    d.irq = |(d.sts & d.mask);

    // Read data phase, one wait state
    case (q.pend_addr)
      `UCS_A_KEY: begin
        rdata[0] = q.unlocked;
      end
      `UCS_A_CTL: begin
        rdata[`UCS_CTL_RANGE_LSB +: 2] = q.range;
        rdata[`UCS_CTL_BYPASS]         = q.bypass;
        rdata[`UCS_CTL_HFEN]           = q.hf_en;
        rdata[`UCS_CTL_SMSRC]          = q.sm_src;
        rdata[`UCS_CTL_DIV_LSB +: 3]   = q.div;
      end
      `UCS_A_USS: begin
        rdata[`UCS_USS_RESTYPE] = q.res_type;
        rdata[`UCS_USS_EN]      = q.uss_en;
        rdata[`UCS_USS_PWR]     = q.pwr_en;
      end
      `UCS_A_STS: begin
        rdata[`UCS_S_W-1:0] = q.sts;
      end
      `UCS_A_MASK: begin
        rdata[`UCS_S_W-1:0] = q.mask;
      end
      `UCS_A_STAT: begin
        rdata[`UCS_ST_STARTED]  = (q.osc == ucs_pkg::UCS_OSC_RUN);
        rdata[`UCS_ST_READY]    = q.ready_prev;
        rdata[`UCS_ST_LOCK]     = q.lock_prev;
        rdata[`UCS_ST_FALLBACK] = q.sts[`UCS_S_HF];
        rdata[`UCS_ST_UNLOCKED] = q.unlocked;
      end
      default: begin
        rdata = '0;
      end
    endcase
    if (q.pend_rd) begin
      d.hrdata    = rdata;
      d.hreadyout = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q           <= '0;
      q.hreadyout <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hreadyout                     = q.hreadyout;
  assign hrdata                        = q.hrdata;
  assign hresp                         = q.hresp;
  assign ultrasonic_osc_enable         = q.uss_en;
  assign ultrasonic_clock_buffered_out = q.buf_out;
  assign hf_xtal_drive_en              = q.xtal_en;
  assign hf_oscillator_clock           = q.hf_clk;
  assign subsystem_clock               = q.sm_clk;
  assign ultrasonic_power_supply_en    = q.pwr_out;
  assign irq                           = q.irq;

endmodule : ucs_clock_ctl

`default_nettype wire

/* testbench/ucs_res_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ucs_res_model #(
  parameter int HALF_NS  = 62,
  parameter int READY_NS = 2000,
  parameter int LOCK_NS  = 3000
) (
  input  wire logic   osc_en,
  input  wire logic   pwr_en,
  output logic        osc_out,
  output logic        supply_ready,
  output logic        pll_lock,
  output logic [15:0] n_edges
);
  // An 8 MHz part, which sits in range 01 of the hf window
  initial begin
    osc_out = 1'b0;
    supply_ready = 1'b0;
    pll_lock = 1'b0;
    n_edges = 16'h0;
  end

  // Swings only while its amplifier is enabled and rests low otherwise
  always begin
    #(HALF_NS);
    osc_out = (osc_en === 1'b1) && !osc_out;
    if (osc_en !== 1'b1)
      n_edges = 16'h0;
    else if (osc_out)
      n_edges = n_edges + 16'h1;
  end

  // The supply reports full power first and the pll locks later
  always begin
    wait (pwr_en === 1'b1);
    #(READY_NS);
    supply_ready = 1'b1;
    #(LOCK_NS);
    pll_lock = 1'b1;
    wait (pwr_en !== 1'b1);
    supply_ready = 1'b0;
    pll_lock = 1'b0;
  end
endmodule : ucs_res_model

`default_nettype wire

/* testbench/ucs_clock_ctl_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module ucs_clock_ctl_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       uss_osc_pin,
  input wire logic       ultrasonic_osc_enable,
  input wire logic       ultrasonic_clock_buffered_out,
  input wire logic       hf_xtal_drive_en,
  input wire logic       ultrasonic_power_supply_en,
  input wire logic       irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ultrasonic_osc_enable may only rise, and hf_xtal_drive_en only move, two or three edges after an accepted write
  wire logic wr_go = hsel & htrans[1] & hready & hwrite;
  wire logic rd_go = hsel & htrans[1] & hready & ~hwrite;

  a_write_no_wait: assert property (wr_go |=> hreadyout)
    else $error("write data phase stalled");
  a_read_one_wait: assert property (rd_go |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_resp_always_okay: assert property (!hresp)
    else $error("error response seen");
  a_enable_by_write: assert property ($rose(ultrasonic_osc_enable) |-> $past(wr_go, 2) || $past(wr_go, 3))
    else $error("oscillator enabled without a write");
  a_drive_by_write: assert property ($changed(hf_xtal_drive_en) |-> $past(wr_go, 2) || $past(wr_go, 3))
    else $error("crystal drive moved without a write");
  a_buf_quiet_pin: assert property (!uss_osc_pin [*6] |-> !ultrasonic_clock_buffered_out)
    else $error("buffered clock high while pin low");
  a_buf_off_disabled: assert property (!ultrasonic_osc_enable [*4] |-> !ultrasonic_clock_buffered_out)
    else $error("buffered clock while oscillator off");
  a_pwr_needs_osc: assert property (!ultrasonic_osc_enable [*4] |-> !ultrasonic_power_supply_en)
    else $error("supply on while oscillator off");

  c_osc_on: cover property ($rose(ultrasonic_osc_enable));
  c_irq_up: cover property ($rose(irq));
  c_pwr_up: cover property ($rose(ultrasonic_power_supply_en));
endmodule : ucs_clock_ctl_chk

bind ucs_clock_ctl ucs_clock_ctl_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .uss_osc_pin(uss_osc_pin),
  .ultrasonic_osc_enable(ultrasonic_osc_enable),
  .ultrasonic_clock_buffered_out(ultrasonic_clock_buffered_out),
  .hf_xtal_drive_en(hf_xtal_drive_en), .ultrasonic_power_supply_en(ultrasonic_power_supply_en),
  .irq(irq)
);

`default_nettype wire

/* testbench/ucs_clock_ctl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ucs_params.svh"

module ucs_clock_ctl_tb;
  localparam int          LIMIT = 90000;
  localparam logic [31:0] ALL   = 32'hFFFFFFFF;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, lf_fault, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        osc_en, buf_out, xtal_en, hf_clk, sub_clk, pwr_en, irq, osc, rdy, lock;
  logic [15:0] n_edges;
  logic        p_buf, p_hf, p_sub;
  int          n_mismatch = 0, n_checks = 0, cyc = 0, c_buf = 0, c_hf = 0, c_sub = 0;

  always #(`UCS_CLK_PERIOD_NS / 2.0) hclk = ~hclk;

  ucs_clock_ctl uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .uss_osc_pin(osc),
    .hf_clock_input_pin(buf_out), .hf_xtal_pin(buf_out), .lf_fault_pin(lf_fault),
    .supply_ready_pin(rdy), .pll_lock_pin(lock), .ultrasonic_osc_enable(osc_en),
    .ultrasonic_clock_buffered_out(buf_out), .hf_xtal_drive_en(xtal_en),
    .hf_oscillator_clock(hf_clk), .subsystem_clock(sub_clk),
    .ultrasonic_power_supply_en(pwr_en), .irq(irq)
  );

  // The buffered output is wired back to the hf inputs only, never to a processor clock
  ucs_res_model res (
    .osc_en(osc_en), .pwr_en(pwr_en), .osc_out(osc), .supply_ready(rdy),
    .pll_lock(lock), .n_edges(n_edges)
  );

  always @(posedge hclk) begin
    c_buf += int'(buf_out && !p_buf);
    c_hf += int'(hf_clk && !p_hf);
    c_sub += int'(sub_clk && !p_sub);
    p_buf = buf_out;
    p_hf = hf_clk;
    p_sub = sub_clk;
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Edge counts of free clocks are only known to within a count
  task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h to %h", $time, got, lo, hi);
    end
  endtask : rng

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0, d);
    chk(d & m, e);
  endtask : rd

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    bus(1'b0, a, 32'h0, d);
    for (int i = 0; i < 3000 && (d & m) !== m; i++) bus(1'b0, a, 32'h0, d);
    chk(d & m, m);
  endtask : poll

  task automatic measure(input int n);
    c_buf = 0;
    c_hf = 0;
    c_sub = 0;
    repeat (n) @(posedge hclk);
  endtask : measure

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    lf_fault = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`UCS_A_KEY, 32'h0, 32'h1);
    rd(`UCS_A_CTL, 32'h0, ALL);
    rd(`UCS_A_STAT, 32'h0, 32'h7);
    wr(`UCS_A_CTL, 32'hD);
    rd(`UCS_A_CTL, 32'h0, ALL);
    wr(`UCS_A_KEY, 32'hA500);
    rd(`UCS_A_KEY, 32'h1, 32'h1);
    for (int r = 0; r < 4; r++) begin
      wr(`UCS_A_CTL, 32'h8 | 32'(r));
      rd(`UCS_A_CTL, 32'h8 | 32'(r), ALL);
      chk(32'(xtal_en), 32'h1);
    end
    wr(`UCS_A_CTL, 32'hD);
    rd(8'h1C, 32'h0, ALL);
    wr(8'h1C, ALL);
    rd(`UCS_A_CTL, 32'hD, ALL);
    chk(32'(xtal_en), 32'h0);
    $display("test registers finished");
    wr(`UCS_A_MASK, 32'h8);
    wr(`UCS_A_USS, 32'h1);
    wr(`UCS_A_USS, 32'h3);
    repeat (2) @(posedge hclk);
    chk(32'(osc_en), 32'h1);
    while (n_edges < 16'h1F4) @(posedge hclk);
    rd(`UCS_A_STAT, 32'h0, 32'h1);
    poll(`UCS_A_STAT, 32'h1);
    rng(32'(n_edges), 32'h200, 32'h202);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h1);
    measure(400);
    rng(c_buf, 32'h1F, 32'h22);
    wr(`UCS_A_STS, 32'h8);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0);
    lf_fault <= 1'b1;
    wr(`UCS_A_MASK, 32'h2);
    repeat (4) @(posedge hclk);
    chk(32'(irq), 32'h1);
    rd(`UCS_A_STS, 32'h6, 32'h6);
    wr(`UCS_A_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0);
    lf_fault <= 1'b0;
    $display("test start finished");
    for (int i = 0; i < 8; i++) begin
      wr(`UCS_A_STS, 32'h7);
      bus(1'b0, `UCS_A_STS, 32'h0, d);
      if (d[2] === 1'b0) break;
    end
    chk(d & 32'h7, 32'h0);
    rd(`UCS_A_STAT, 32'h0, 32'h8);
    wr(`UCS_A_CTL, 32'h9);
    measure(400);
    rng(c_hf, 32'h1F, 32'h22);
    wr(`UCS_A_CTL, 32'h1D);
    measure(400);
    rng(c_sub, 32'h13, 32'h15);
    for (int v = 0; v < 3; v++) begin
      wr(`UCS_A_CTL, 32'hD | (32'(v) << 8));
      measure(400);
      rng(c_hf, 32'h1F, 32'h22);
      rng(c_sub, 32'(c_hf >> v) - 32'h1, 32'(c_hf >> v) + 32'h1);
    end
    wr(`UCS_A_USS, 32'h7);
    poll(`UCS_A_STAT, 32'h6);
    chk(32'(pwr_en), 32'h1);
    $display("test bypass finished");
    wr(`UCS_A_USS, 32'h1);
    repeat (300) @(posedge hclk);
    chk(32'(buf_out), 32'h0);
    rd(`UCS_A_STS, 32'h5, 32'h5);
    rd(`UCS_A_STAT, 32'h8, 32'h8);
    measure(400);
    rng(c_hf, 32'h13, 32'h15);
    wr(`UCS_A_STS, 32'h7);
    rd(`UCS_A_STS, 32'h5, 32'h5);
    $display("test fault finished");
    wr(`UCS_A_USS, 32'h0);
    wr(`UCS_A_USS, 32'h2);
    while (n_edges < 16'hFA0) @(posedge hclk);
    rd(`UCS_A_STAT, 32'h0, 32'h1);
    poll(`UCS_A_STAT, 32'h1);
    rng(32'(n_edges), 32'h1000, 32'h1002);
    wr(`UCS_A_KEY, 32'h0);
    wr(`UCS_A_CTL, 32'h0);
    rd(`UCS_A_CTL, 32'h20D, ALL);
    $display("test crystal finished");
    wrap_up();
  end
endmodule : ucs_clock_ctl_tb

`default_nettype wire
